// ===== hw/cmlr_regs.sv
// Purpose: SMBus slave with impedance, coupling, write guard and loss flag registers.
// Assumes: rst is the power-on reset; mclk far faster than SMBus clock.
// Notes:   No clock stretching; SDA is open drain as out/oe pair.
//
// Behaviour
// (R01) Once the permanent guard bit is written to one, every later register write is refused.
// (R02) The permanent guard bit stays set against all writes and only power-on reset clears it.
// (R03) The clearable guard bit blocks register writes while set, and a write of one clears it.
// (R04) The input 1 loss flag is set on loss of input 1 and held until a write of one clears it.
// (R05) The input 0 loss flag is set on loss of input 0 and held until a write of one clears it.
// (R06) Coupling bit 3 enables the input 1 bias resistor for AC coupling, zero after reset.
// (R07) Coupling bit 1 enables the input 0 bias resistor for AC coupling, zero after reset.
// (R08) Coupling bit 2 enables the input 1 termination, zero after reset.
// (R09) Coupling bit 0 enables the input 0 termination, zero after reset.
// (R10) The loss detector drives the active-low open-drain loss pin and sets the loss flags.
// (R11) The loss pin follows loss of the currently selected input only.
// (R12) Writes to the clearable guard byte still land while only the clearable guard is set.
// (R13) The impedance byte holds one select per output 8 to 15, loaded from the strap at power-up.
`timescale 1ns/1ps
`default_nettype none
module cmlr_regs
    import cmlr_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h68
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output var  logic       sda_out,
    output var  logic       sda_oe,
    input  wire logic [7:0] impedance_strap,
    input  wire logic       input0_loss_raw,
    input  wire logic       input1_loss_raw,
    input  wire logic       input_select,
    output var  logic       loss_pin_n_out,
    output var  logic       loss_pin_n_oe,
    output var  logic [7:0] upper_impedance_select,
    output var  logic       input0_termination_enable,
    output var  logic       input0_bias_enable,
    output var  logic       input1_termination_enable,
    output var  logic       input1_bias_enable
);

    // Synchronised pins
    logic       scl_s;
    logic       sda_s;
    logic       loss0_s;
    logic       loss1_s;
    logic       sel_s;
    logic [7:0] strap_s;

    cmlr_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_bus_sync (
        .mclk     (mclk),
        .rst      (rst),
        .async_in ({scl_in, sda_in}),
        .sync_out ({scl_s, sda_s})
    );

    cmlr_sync #(.WIDTH(11), .RESET_VAL(11'h000)) u_pin_sync (
        .mclk     (mclk),
        .rst      (rst),
        .async_in ({impedance_strap, input0_loss_raw, input1_loss_raw, input_select}),
        .sync_out ({strap_s, loss0_s, loss1_s, sel_s})
    );

    // Bus edge and condition detection
    logic scl_d_r;
    logic sda_d_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    wire scl_rise  = scl_s & ~scl_d_r;
    wire scl_fall  = ~scl_s & scl_d_r;
    wire bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire bus_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // Protocol state
    cmlr_state_t state_r;
    logic [3:0]  bitcnt_r;
    logic [7:0]  shift_r;
    logic [7:0]  tx_r;
    logic [7:0]  ptr_r;
    logic        ack_seen_r;

    // Register state
    logic [7:0] impedance_r;
    logic [3:0] coupling_r;
    logic       perm_guard_r;
    logic       clr_guard_r;
    logic       loss0_flag_r;
    logic       loss1_flag_r;
    logic [1:0] strap_wait_r;
    logic       strap_done_r;

    wire byte_done   = (bitcnt_r == CMLR_BITS_PER_BYTE);
    wire addr_match  = (shift_r[7:1] == DEV_ADDR);
    wire data_in     = scl_fall & byte_done & (state_r == CMLR_WDATA);

    // Guard decode
    wire at_impedance = (ptr_r == CMLR_OFS_IMPEDANCE);
    wire at_coupling  = (ptr_r == CMLR_OFS_COUPLING);
    wire at_perm      = (ptr_r == CMLR_OFS_PERM_GUARD);
    wire at_clr       = (ptr_r == CMLR_OFS_CLR_GUARD);
    wire write_open   = ~perm_guard_r & (~clr_guard_r | at_clr); // R01 R03 R12
    wire wr_fire      = data_in & write_open;
    wire wr_impedance = wr_fire & at_impedance;
    wire wr_coupling  = wr_fire & at_coupling;
    wire wr_perm      = wr_fire & at_perm;
    wire wr_clr       = wr_fire & at_clr;

    // Read selection
    wire [7:0] rd_coupling = {4'h0, coupling_r};
    wire [7:0] rd_perm     = {7'h00, perm_guard_r};
    wire [7:0] rd_clr      = {5'h00, loss1_flag_r, loss0_flag_r, clr_guard_r};

    // Every register value is an argument, so the wires below follow all of them
    function automatic logic [7:0] read_byte(input logic [7:0] ofs, input logic [7:0] imp_v,
                                             input logic [7:0] cpl_v, input logic [7:0] perm_v,
                                             input logic [7:0] clr_v);
        logic [7:0] val;
        val = 8'h00;
        if (ofs == CMLR_OFS_IMPEDANCE) begin
            val = imp_v;
        end else if (ofs == CMLR_OFS_COUPLING) begin
            val = cpl_v;
        end else if (ofs == CMLR_OFS_PERM_GUARD) begin
            val = perm_v;
        end else if (ofs == CMLR_OFS_CLR_GUARD) begin
            val = clr_v;
        end
        return val;
    endfunction : read_byte

    wire [7:0] ptr_inc     = ptr_r + 8'h01;
    wire [7:0] rd_now      = read_byte(ptr_r, impedance_r, rd_coupling, rd_perm, rd_clr);
    wire [7:0] rd_next     = read_byte(ptr_inc, impedance_r, rd_coupling, rd_perm, rd_clr);

    // Protocol engine
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r    <= CMLR_IDLE;
            bitcnt_r   <= 4'h0;
            shift_r    <= 8'h00;
            tx_r       <= 8'h00;
            ptr_r      <= 8'h00;
            ack_seen_r <= 1'b0;
            sda_oe     <= 1'b0;
        end else if (bus_start) begin
            state_r  <= CMLR_ADDR;
            bitcnt_r <= 4'h0;
            sda_oe   <= 1'b0;
        end else if (bus_stop) begin
            state_r <= CMLR_IDLE;
            sda_oe  <= 1'b0;
        end else if (scl_rise) begin
            if (state_r == CMLR_ADDR || state_r == CMLR_CMD || state_r == CMLR_WDATA) begin
                shift_r  <= {shift_r[6:0], sda_s};
                bitcnt_r <= bitcnt_r + 4'h1;
            end
            if (state_r == CMLR_RDATA_ACK) begin
                ack_seen_r <= ~sda_s;
            end
        end else if (scl_fall) begin
            case (state_r)
                CMLR_ADDR: begin
                    if (byte_done) begin
                        if (addr_match) begin
                            state_r <= CMLR_ADDR_ACK;
                            sda_oe  <= 1'b1;
                        end else begin
                            state_r <= CMLR_IDLE;
                        end
                    end
                end
                CMLR_ADDR_ACK: begin
                    bitcnt_r <= 4'h0;
                    if (shift_r[0]) begin
                        state_r <= CMLR_RDATA;
                        tx_r    <= rd_now;
                        sda_oe  <= ~rd_now[7];
                    end else begin
                        state_r <= CMLR_CMD;
                        sda_oe  <= 1'b0;
                    end
                end
                CMLR_CMD: begin
                    if (byte_done) begin
                        ptr_r   <= shift_r;
                        state_r <= CMLR_CMD_ACK;
                        sda_oe  <= 1'b1;
                    end
                end
                CMLR_CMD_ACK: begin
                    state_r  <= CMLR_WDATA;
                    bitcnt_r <= 4'h0;
                    sda_oe   <= 1'b0;
                end
                CMLR_WDATA: begin
                    // Refused writes are still acknowledged; the host reads back
                    if (byte_done) begin
                        state_r <= CMLR_WDATA_ACK;
                        sda_oe  <= 1'b1;
                    end
                end
                CMLR_WDATA_ACK: begin
                    state_r  <= CMLR_WDATA;
                    bitcnt_r <= 4'h0;
                    ptr_r    <= ptr_inc;
                    sda_oe   <= 1'b0;
                end
                CMLR_RDATA: begin
                    if (bitcnt_r == CMLR_LAST_TX_BIT) begin
                        state_r <= CMLR_RDATA_ACK;
                        sda_oe  <= 1'b0;
                    end else begin
                        bitcnt_r <= bitcnt_r + 4'h1;
                        tx_r     <= {tx_r[6:0], 1'b0};
                        sda_oe   <= ~tx_r[6];
                    end
                end
                CMLR_RDATA_ACK: begin
                    if (ack_seen_r) begin
                        state_r  <= CMLR_RDATA;
                        bitcnt_r <= 4'h0;
                        ptr_r    <= ptr_inc;
                        tx_r     <= rd_next;
                        sda_oe   <= ~rd_next[7];
                    end else begin
                        state_r <= CMLR_IDLE;
                    end
                end
                default: begin
                    state_r <= CMLR_IDLE;
                    sda_oe  <= 1'b0;
                end
            endcase
        end
    end

    // Strap capture after the synchroniser has settled
    always_ff @(posedge mclk) begin
        if (rst) begin
            strap_wait_r <= 2'h0;
            strap_done_r <= 1'b0;
        end else if (!strap_done_r) begin
            strap_wait_r <= strap_wait_r + 2'h1;
            strap_done_r <= (strap_wait_r == CMLR_STRAP_SETTLE);
        end
    end

    wire strap_load = ~strap_done_r & (strap_wait_r == CMLR_STRAP_SETTLE);

    always_ff @(posedge mclk) begin
        if (rst) begin
            impedance_r <= 8'h00;
        end else if (strap_load) begin
            impedance_r <= strap_s; // R13
        end else if (wr_impedance) begin
            impedance_r <= shift_r; // R13
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            coupling_r <= CMLR_COUPLING_RST; // R06 R07 R08 R09
        end else if (wr_coupling) begin
            coupling_r <= shift_r[3:0]; // R06 R07 R08 R09
        end
    end

    // Sticky: nothing but power-on reset lowers it
    always_ff @(posedge mclk) begin
        if (rst) begin
            perm_guard_r <= CMLR_GUARD_RST;
        end else if (wr_perm & shift_r[CMLR_BIT_PERM_GUARD]) begin
            perm_guard_r <= 1'b1; // R01 R02
        end
    end

    // Writing one toggles: arms the guard when clear, releases it when set
    wire clr_guard_nxt = (wr_clr & shift_r[CMLR_BIT_CLR_GUARD]) ? ~clr_guard_r // R03 R12
                                                                : clr_guard_r;

    // Detection wins over a clear in the same cycle
    wire clr_loss0    = wr_clr & shift_r[CMLR_BIT_IN0_LOSS];
    wire clr_loss1    = wr_clr & shift_r[CMLR_BIT_IN1_LOSS];
    wire loss0_flag_nxt = (loss0_flag_r & ~clr_loss0) | loss0_s; // R05 R10
    wire loss1_flag_nxt = (loss1_flag_r & ~clr_loss1) | loss1_s; // R04 R10

    always_ff @(posedge mclk) begin
        if (rst) begin
            clr_guard_r  <= CMLR_GUARD_RST;
            loss0_flag_r <= CMLR_FLAG_RST;
            loss1_flag_r <= CMLR_FLAG_RST;
        end else begin
            clr_guard_r  <= clr_guard_nxt;
            loss0_flag_r <= loss0_flag_nxt;
            loss1_flag_r <= loss1_flag_nxt;
        end
    end

    // Pin pulled low during reset, then follows the synchronised loss of the selected input
    wire sel_loss = sel_s ? loss1_s : loss0_s; // R11

    always_ff @(posedge mclk) begin
        if (rst) begin
            loss_pin_n_oe <= 1'b1;
        end else begin
            loss_pin_n_oe <= sel_loss; // R10 R11
        end
    end

    assign loss_pin_n_out            = 1'b0;
    assign sda_out                   = 1'b0;
    assign upper_impedance_select    = impedance_r;
    assign input0_termination_enable = coupling_r[CMLR_BIT_IN0_TERM]; // R09
    assign input0_bias_enable        = coupling_r[CMLR_BIT_IN0_BIAS]; // R07
    assign input1_termination_enable = coupling_r[CMLR_BIT_IN1_TERM]; // R08
    assign input1_bias_enable        = coupling_r[CMLR_BIT_IN1_BIAS]; // R06

endmodule : cmlr_regs
`default_nettype wire

// ===== hw/cmlr_sync.sv
// Purpose: Two-flop synchroniser for a group of asynchronous levels.
// Assumes: Inputs are slow levels; no bus coherency is needed.
// Notes:   First stage is read only by the second stage.
`timescale 1ns/1ps
`default_nettype none
module cmlr_sync #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_r   <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule : cmlr_sync
`default_nettype wire

// ===== shared/cmlr_pkg.sv
// Purpose: Shared constants for the clock mux lock and loss register bank.
// Assumes: Byte-wide registers addressed by an 8-bit command code.
// Notes:   Offsets are the printed byte numbers.
package cmlr_pkg;

    localparam logic [7:0] CMLR_OFS_IMPEDANCE   = 8'h15;
    localparam logic [7:0] CMLR_OFS_COUPLING    = 8'h23;
    localparam logic [7:0] CMLR_OFS_PERM_GUARD  = 8'h26;
    localparam logic [7:0] CMLR_OFS_CLR_GUARD   = 8'h27;

    // Field positions in the coupling register
    localparam int CMLR_BIT_IN0_TERM  = 0;
    localparam int CMLR_BIT_IN0_BIAS  = 1;
    localparam int CMLR_BIT_IN1_TERM  = 2;
    localparam int CMLR_BIT_IN1_BIAS  = 3;

    // Field positions in the guard registers
    localparam int CMLR_BIT_PERM_GUARD = 0;
    localparam int CMLR_BIT_CLR_GUARD  = 0;
    localparam int CMLR_BIT_IN0_LOSS   = 1;
    localparam int CMLR_BIT_IN1_LOSS   = 2;

    localparam logic [3:0] CMLR_COUPLING_RST = 4'h0;
    localparam logic       CMLR_GUARD_RST    = 1'b0;
    localparam logic       CMLR_FLAG_RST     = 1'b0;

    // Cycles after reset before the synchronised strap is trusted
    localparam logic [1:0] CMLR_STRAP_SETTLE = 2'h3;
    localparam logic [3:0] CMLR_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] CMLR_LAST_TX_BIT   = 4'h7;

    typedef enum {
        CMLR_IDLE,
        CMLR_ADDR,
        CMLR_ADDR_ACK,
        CMLR_CMD,
        CMLR_CMD_ACK,
        CMLR_WDATA,
        CMLR_WDATA_ACK,
        CMLR_RDATA,
        CMLR_RDATA_ACK
    } cmlr_state_t;

endpackage : cmlr_pkg

// ===== testbench/cmlr_host.sv
// Purpose: Behavioural SMBus host driving the register bank.
// Assumes: Bus phases of 10 mclk; the device never stretches.
// Notes:   Data line is open drain; released level is the pull-up.
`timescale 1ns/1ps
`default_nettype none
module cmlr_host #(
    parameter logic [6:0] ADDR = 7'h68
) (
    input  wire logic mclk,
    input  wire logic sda_line,
    output var  logic scl,
    output var  logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic hw(input int n);
        repeat (n) @(negedge mclk);
    endtask : hw
    task automatic pulse(output logic b);
        hw(5);
        scl = 1'b1;
        hw(5);
        b = sda_line;
        hw(5);
        scl = 1'b0;
        hw(5);
    endtask : pulse
    task automatic put(input logic b);
        logic s;
        sda_low = !b;
        pulse(s);
    endtask : put
    task automatic get(output logic b);
        sda_low = 1'b0;
        pulse(b);
    endtask : get
    task automatic start();
        sda_low = 1'b0;
        hw(5);
        scl = 1'b1;
        hw(10);
        sda_low = 1'b1;
        hw(10);
        scl = 1'b0;
        hw(5);
    endtask : start
    task automatic stop();
        sda_low = 1'b1;
        hw(5);
        scl = 1'b1;
        hw(10);
        sda_low = 1'b0;
        hw(10);
    endtask : stop
    task automatic xfer(input logic [7:0] d, output logic ack);
        logic k;
        for (int i = 7; i >= 0; i--) put(d[i]);
        get(k);
        ack = !k;
    endtask : xfer
    task automatic wr(input logic [6:0] a, input logic [7:0] o, d, output logic ack);
        logic k;
        start();
        xfer({a, 1'b0}, ack);
        xfer(o, k);
        xfer(d, k);
        stop();
    endtask : wr
    task automatic rd(input logic [7:0] o, output logic [7:0] d);
        logic k;
        start();
        xfer({ADDR, 1'b0}, k);
        xfer(o, k);
        start();
        xfer({ADDR, 1'b1}, k);
        for (int i = 7; i >= 0; i--) get(d[i]);
        put(1'b1);
        stop();
    endtask : rd
    task automatic wr2(input logic [7:0] o, d0, d1);
        logic k;
        start();
        xfer({ADDR, 1'b0}, k);
        xfer(o, k);
        xfer(d0, k);
        xfer(d1, k);
        stop();
    endtask : wr2
    task automatic rd2(input logic [7:0] o, output logic [15:0] d);
        logic k;
        start();
        xfer({ADDR, 1'b0}, k);
        xfer(o, k);
        start();
        xfer({ADDR, 1'b1}, k);
        for (int i = 15; i >= 8; i--) get(d[i]);
        put(1'b0);
        for (int i = 7; i >= 0; i--) get(d[i]);
        put(1'b1);
        stop();
    endtask : rd2
endmodule : cmlr_host
`default_nettype wire

// ===== testbench/cmlr_props.sv
// Purpose: Port assertions for the lock and loss register bank.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to the design from the bench top.
`timescale 1ns/1ps
`default_nettype none
module cmlr_props (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic [7:0] impedance_strap,
    input wire logic       input0_loss_raw,
    input wire logic       input1_loss_raw,
    input wire logic       input_select,
    input wire logic       loss_pin_n_out,
    input wire logic       loss_pin_n_oe,
    input wire logic [7:0] upper_impedance_select,
    input wire logic       input0_termination_enable,
    input wire logic       input0_bias_enable,
    input wire logic       input1_termination_enable,
    input wire logic       input1_bias_enable
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic [3:0] cpl;
    assign cpl = {input1_bias_enable, input1_termination_enable,
                  input0_bias_enable, input0_termination_enable};

    reset_outputs_a: assert property (disable iff (1'b0) rst |=>
        !sda_oe && loss_pin_n_oe && cpl == 4'h0 && upper_impedance_select == 8'h00)
        else $error("outputs wrong after reset");
    open_drain_a: assert property (!sda_out && !loss_pin_n_out)
        else $error("open-drain data not low");
    loss_pin_a: assert property (($stable(input_select) && $stable(input0_loss_raw)
        && $stable(input1_loss_raw)) [*5]
        |-> loss_pin_n_oe == (input_select ? input1_loss_raw : input0_loss_raw))
        else $error("loss pin not following selected input");
    strap_load_a: assert property ($fell(rst)
        |-> ##[5:8] upper_impedance_select == impedance_strap)
        else $error("impedance not loaded from strap");
    cfg_update_a: assert property (!$stable(cpl) |-> !scl_in && !$past(scl_in, 2))
        else $error("coupling changed outside a write");
    ack_rise_a: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in, 2))
        else $error("data pulled low while clock high");
    ack_fall_a: assert property ($fell(sda_oe) |-> !scl_in)
        else $error("data released while clock high");
    sda_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*8])
        else $error("data pull too short");

    cover property ($rose(sda_oe));
    cover property ($rose(input1_bias_enable));
    cover property (input_select && $fell(loss_pin_n_oe));
endmodule : cmlr_props
`default_nettype wire

// ===== testbench/cmlr_regs_tb_top.sv
// Purpose: Self-checking bench for the lock and loss register bank.
// Assumes: Host model in cmlr_host; checker bound below.
// Notes:   Table rows are {offset, write, expected read}.
`timescale 1ns/1ps
`default_nettype none
module cmlr_regs_tb_top;
    import cmlr_pkg::*;
    localparam logic [6:0] ADDR = 7'h68;
    logic        mclk, rst, scl, host_low, sda_line, sda_out, sda_oe;
    logic        loss0, loss1, sel, pin_out, pin_oe, t0, b0, t1, b1, ack;
    logic [7:0]  strap, imp, rdat;
    logic [15:0] rd16;
    logic [23:0] rows [5];
    int          bad_count;
    int          cmp_count;
    assign sda_line = !(host_low || (sda_oe && !sda_out));
    cmlr_regs #(.DEV_ADDR(ADDR)) cmlr_regs_inst (.mclk(mclk), .rst(rst), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .impedance_strap(strap),
        .input0_loss_raw(loss0), .input1_loss_raw(loss1), .input_select(sel),
        .loss_pin_n_out(pin_out), .loss_pin_n_oe(pin_oe), .upper_impedance_select(imp),
        .input0_termination_enable(t0), .input0_bias_enable(b0),
        .input1_termination_enable(t1), .input1_bias_enable(b1));
    cmlr_host #(.ADDR(ADDR)) cmlr_host_inst (.mclk(mclk), .sda_line(sda_line),
        .scl(scl), .sda_low(host_low));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic w(input logic [7:0] o, input logic [7:0] d);
        cmlr_host_inst.wr(ADDR, o, d, ack);
        chk("address_ack", 8'h01, {7'h0, ack});
    endtask : w
    task automatic rc(input logic [7:0] o, input logic [7:0] e);
        cmlr_host_inst.rd(o, rdat);
        chk("readback", e, rdat);
    endtask : rc
    task automatic cc(input logic [3:0] e);
        chk("coupling", {4'h0, e}, {4'h0, b1, t1, b0, t0});
    endtask : cc
    task automatic lp(input logic e);
        repeat (10) @(negedge mclk);
        chk("loss_pin", {7'h0, e}, {7'h0, pin_oe});
    endtask : lp
    task automatic rst_seq();
        rst = 1'b1;
        repeat (12) @(negedge mclk);
        rst = 1'b0;
        repeat (20) @(negedge mclk);
    endtask : rst_seq
    task automatic results();
        if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    initial begin
        // Long enough for about eighty bus transactions
        repeat (60000) @(posedge mclk);
        bad_count++;
        results();
    end
    initial begin
        rst = 1'b1;
        strap = 8'h3c;
        {loss0, loss1, sel} = 3'h0;
        bad_count = 0;
        cmp_count = 0;
        rows = '{{CMLR_OFS_IMPEDANCE, 8'ha5, 8'ha5}, {CMLR_OFS_IMPEDANCE, 8'h5a, 8'h5a},
                 {CMLR_OFS_COUPLING, 8'hf5, 8'h05}, {CMLR_OFS_COUPLING, 8'h0a, 8'h0a},
                 {8'h16, 8'hff, 8'h00}};
        rst_seq();
        chk("impedance", strap, imp);
        cc(4'h0);
        rc(CMLR_OFS_COUPLING, 8'h00);
        rc(CMLR_OFS_PERM_GUARD, 8'h00);
        rc(CMLR_OFS_CLR_GUARD, 8'h00);
        foreach (rows[i]) begin
            w(rows[i][23:16], rows[i][15:8]);
            rc(rows[i][23:16], rows[i][7:0]);
            if (rows[i][23:16] == CMLR_OFS_COUPLING) cc(rows[i][3:0]);
            if (rows[i][23:16] == CMLR_OFS_IMPEDANCE) chk("impedance", rows[i][7:0], imp);
        end
        // Burst write and read: pointer steps from an unmapped byte into 0x15
        cmlr_host_inst.wr2(8'h14, 8'hff, 8'hc3);
        cmlr_host_inst.rd2(8'h14, rd16);
        chk("burst_read", 8'h00, rd16[15:8]);
        chk("burst_read", 8'hc3, rd16[7:0]);
        chk("impedance", 8'hc3, imp);
        cmlr_host_inst.wr(7'h69, CMLR_OFS_COUPLING, 8'hff, ack);
        chk("address_ack", 8'h00, {7'h0, ack});
        rc(CMLR_OFS_COUPLING, 8'h0a);
        loss0 = 1'b1;
        lp(1'b1);
        loss0 = 1'b0;
        loss1 = 1'b1;
        lp(1'b0);
        sel = 1'b1;
        lp(1'b1);
        loss1 = 1'b0;
        lp(1'b0);
        // Losses gone before the read, so the flags must be sticky
        rc(CMLR_OFS_CLR_GUARD, 8'h06);
        w(CMLR_OFS_CLR_GUARD, 8'h02);
        rc(CMLR_OFS_CLR_GUARD, 8'h04);
        w(CMLR_OFS_CLR_GUARD, 8'h04);
        rc(CMLR_OFS_CLR_GUARD, 8'h00);
        // Clear while the loss persists: detection must win
        loss0 = 1'b1;
        w(CMLR_OFS_CLR_GUARD, 8'h02);
        rc(CMLR_OFS_CLR_GUARD, 8'h02);
        loss0 = 1'b0;
        w(CMLR_OFS_CLR_GUARD, 8'h02);
        rc(CMLR_OFS_CLR_GUARD, 8'h00);
        w(CMLR_OFS_CLR_GUARD, 8'h01);
        rc(CMLR_OFS_CLR_GUARD, 8'h01);
        w(CMLR_OFS_COUPLING, 8'h0f);
        rc(CMLR_OFS_COUPLING, 8'h0a);
        w(CMLR_OFS_CLR_GUARD, 8'h01);
        rc(CMLR_OFS_CLR_GUARD, 8'h00);
        w(CMLR_OFS_COUPLING, 8'h03);
        rc(CMLR_OFS_COUPLING, 8'h03);
        w(CMLR_OFS_PERM_GUARD, 8'h01);
        rc(CMLR_OFS_PERM_GUARD, 8'h01);
        w(CMLR_OFS_PERM_GUARD, 8'h00);
        rc(CMLR_OFS_PERM_GUARD, 8'h01);
        w(CMLR_OFS_COUPLING, 8'h0c);
        rc(CMLR_OFS_COUPLING, 8'h03);
        cc(4'h3);
        w(CMLR_OFS_CLR_GUARD, 8'h01);
        rc(CMLR_OFS_CLR_GUARD, 8'h00);
        rst_seq();
        rc(CMLR_OFS_PERM_GUARD, 8'h00);
        cc(4'h0);
        results();
    end
endmodule : cmlr_regs_tb_top
bind cmlr_regs cmlr_props cmlr_props_inst (.mclk(mclk), .rst(rst), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .impedance_strap(impedance_strap),
    .input0_loss_raw(input0_loss_raw), .input1_loss_raw(input1_loss_raw),
    .input_select(input_select), .loss_pin_n_out(loss_pin_n_out),
    .loss_pin_n_oe(loss_pin_n_oe), .upper_impedance_select(upper_impedance_select),
    .input0_termination_enable(input0_termination_enable),
    .input0_bias_enable(input0_bias_enable),
    .input1_termination_enable(input1_termination_enable),
    .input1_bias_enable(input1_bias_enable));
`default_nettype wire
